/* File: hdl/bmam_pkg.sv */
/*
  bmam_pkg: constants for the banked memory address map.
  assumes a single core clock; used by bmam_address_map and its bench.
*/
package bmam_pkg;
  localparam int PC_WIDTH = 13;
  localparam int INSTR_WIDTH = 14;
  localparam int PMEM_DEPTH_8K = 8192;
  localparam int PMEM_DEPTH_4K = 4096;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] INTR_VECTOR = 13'h0004;
  localparam int BANK_SEL_HIGH_BIT = 6;
  localparam int BANK_SEL_LOW_BIT = 5;
  localparam logic [6:0] OFS_INDIRECT = 7'h00;
  localparam logic [6:0] OFS_STATUS = 7'h03;
  localparam logic [6:0] OFS_POINTER = 7'h04;
  localparam logic [6:0] OFS_GPR_FIRST = 7'h20;
  localparam logic [6:0] OFS_BANKED_GPR_FIRST = 7'h20;
  localparam logic [6:0] OFS_SHARED_FIRST = 7'h70;
  localparam int BANK0_GPR_WORDS = 96;
  localparam int BANKED_GPR_WORDS = 80;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  typedef enum logic [2:0] {
    BMAM_SEL_NONE = 3'b001,
    BMAM_SEL_SFR = 3'b010,
    BMAM_SEL_GPR = 3'b100
  } bmam_sel_t;
endpackage : bmam_pkg

/* File: hdl/bmam_address_map.sv */
/*
  bmam_address_map: program counter, vectors, banked data decode,
  mirrored core registers, indirect access and general purpose ram.
  assumes the core issues one fetch and one data access per clock.
*/
`timescale 1ns/1ps
`default_nettype none
module bmam_address_map
  import bmam_pkg::*;
#(
  parameter int PMEM_DEPTH = PMEM_DEPTH_8K
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic fetch_advance_i,
  input wire logic intr_take_i,
  input wire logic jump_i,
  input wire logic [12:0] jump_addr_i,
  output logic [12:0] fetch_addr_o,
  output logic [12:0] pc_o,
  input wire logic data_req_i,
  input wire logic data_we_i,
  input wire logic [6:0] file_addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] status_core_bits_i,
  input wire logic status_core_we_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic [8:0] data_addr_o,
  output logic [7:0] status_o,
  output logic [7:0] file_select_pointer_o
);
  localparam int PM_BITS = $clog2(PMEM_DEPTH);
  localparam int GPR_WORDS = BANK0_GPR_WORDS + 3 * BANKED_GPR_WORDS;

  logic [12:0] pc_reg;
  logic [12:0] pc_next;
  logic [12:0] fetch_addr_reg;
  logic [7:0] status_reg;
  logic [7:0] file_select_pointer_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic [8:0] data_addr_reg;
  logic [7:0] gpr_mem [GPR_WORDS];
  logic [8:0] dir_addr;
  logic [8:0] eff_addr;
  logic [1:0] eff_bank;
  logic [6:0] eff_ofs;
  logic is_indirect;
  bmam_sel_t sel;
  logic [8:0] gpr_index;
  logic gpr_hit;
  logic [7:0] rd_value;
  logic status_wr;
  logic ptr_wr;

  // program counter
  always_comb begin
    pc_next = pc_reg;
    if (intr_take_i) begin
      pc_next = INTR_VECTOR;
    end else if (jump_i) begin
      pc_next = jump_addr_i;
    end else if (fetch_advance_i) begin
      pc_next = pc_reg + 13'h0001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pc_reg <= RESET_VECTOR;
      fetch_addr_reg <= RESET_VECTOR;
    end else begin
      pc_reg <= pc_next;
      // only implemented low bits reach the array
      fetch_addr_reg <= 13'(pc_next[PM_BITS-1:0]);
    end
  end
  assign pc_o = pc_reg;
  assign fetch_addr_o = fetch_addr_reg;

  // data address decode
  assign dir_addr = {status_reg[BANK_SEL_HIGH_BIT],
                     status_reg[BANK_SEL_LOW_BIT], file_addr_i};
  assign is_indirect = (file_addr_i == OFS_INDIRECT);
  // pointer supplies low 8 bits, bank_select_high the ninth
  assign eff_addr = is_indirect ?
    {status_reg[BANK_SEL_HIGH_BIT], file_select_pointer_reg} :
    dir_addr;
  assign eff_bank = eff_addr[8:7];
  assign eff_ofs = eff_addr[6:0];

  always_comb begin
    gpr_hit = 1'b0;
    gpr_index = 9'h000;
    sel = BMAM_SEL_NONE;
    if (eff_ofs == OFS_STATUS || eff_ofs == OFS_POINTER ||
        eff_ofs == OFS_INDIRECT) begin
      sel = BMAM_SEL_SFR;
    end else if (eff_ofs >= OFS_SHARED_FIRST) begin
      sel = BMAM_SEL_GPR;
      gpr_hit = 1'b1;
      gpr_index = 9'(eff_ofs - OFS_GPR_FIRST);
    end else if (eff_ofs >= OFS_GPR_FIRST) begin
      sel = BMAM_SEL_GPR;
      gpr_hit = 1'b1;
      if (eff_bank == 2'b00) begin
        gpr_index = 9'(eff_ofs - OFS_GPR_FIRST);
      end else begin
        gpr_index = 9'(BANK0_GPR_WORDS + (eff_bank - 1) * BANKED_GPR_WORDS +
                        (eff_ofs - OFS_GPR_FIRST));
      end
    end
  end

  always_comb begin
    rd_value = 8'h00;
    unique case (sel)
      BMAM_SEL_SFR: begin
        if (eff_ofs == OFS_STATUS) begin
          rd_value = status_reg;
        end else if (eff_ofs == OFS_POINTER) begin
          rd_value = file_select_pointer_reg;
        end
      end
      BMAM_SEL_GPR: begin
        rd_value = gpr_hit ? gpr_mem[gpr_index] : 8'h00;
      end
      BMAM_SEL_NONE: begin
        rd_value = 8'h00;
      end
    endcase
  end

  assign status_wr = data_req_i && data_we_i && sel == BMAM_SEL_SFR &&
                     eff_ofs == OFS_STATUS;
  assign ptr_wr = data_req_i && data_we_i && sel == BMAM_SEL_SFR &&
                  eff_ofs == OFS_POINTER;

  // core registers, mirrored in all banks
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      status_reg <= STATUS_RESET;
      file_select_pointer_reg <= POINTER_RESET;
    end else begin
      if (status_wr) begin
        status_reg <= wdata_i;
      end else if (status_core_we_i) begin
        status_reg <= status_core_bits_i;
      end
      if (ptr_wr) begin
        file_select_pointer_reg <= wdata_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (data_req_i && data_we_i && gpr_hit) begin
      gpr_mem[gpr_index] <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      data_addr_reg <= 9'h000;
    end else begin
      rvalid_reg <= data_req_i && !data_we_i;
      if (data_req_i) begin
        rdata_reg <= rd_value;
        data_addr_reg <= eff_addr;
      end
    end
  end
  assign rdata_o = rdata_reg;
  assign rvalid_o = rvalid_reg;
  assign data_addr_o = data_addr_reg;
  assign status_o = status_reg;
  assign file_select_pointer_o = file_select_pointer_reg;

  // fetch side checks
  chk_reset_vector: assert property (@(posedge ref_clk_i)
    $past(reset_i) |-> pc_reg == RESET_VECTOR)
    else $error("pc not at reset vector");

  chk_reset_state: assert property (@(posedge ref_clk_i)
    $past(reset_i) |-> fetch_addr_reg == RESET_VECTOR &&
    status_reg == STATUS_RESET && file_select_pointer_reg == POINTER_RESET &&
    !rvalid_reg && rdata_reg == 8'h00)
    else $error("state not cleared by reset");

  chk_intr_vector: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    intr_take_i |=> pc_reg == INTR_VECTOR)
    else $error("interrupt vector not taken");

  chk_jump_target: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    jump_i && !intr_take_i |=> pc_reg == $past(jump_addr_i))
    else $error("jump target not loaded");

  chk_fetch_wrap: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    1'b1 |=> fetch_addr_reg == 13'(pc_reg % PMEM_DEPTH))
    else $error("fetch address not wrapped");

  chk_fetch_depth: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    fetch_addr_reg < PMEM_DEPTH)
    else $error("fetch address beyond depth");

  chk_pc_step: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    fetch_advance_i && !intr_take_i && !jump_i |=>
    pc_reg == $past(pc_reg) + 13'h0001)
    else $error("pc did not advance");

  // data side checks
  chk_bank_form: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    data_req_i && !is_indirect |=>
    data_addr_reg == {$past(status_reg[6:5]), $past(file_addr_i)})
    else $error("direct address malformed");

  chk_indirect_addr: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    data_req_i && is_indirect |=>
    data_addr_reg == {$past(status_reg[6]), $past(file_select_pointer_reg)})
    else $error("indirect address wrong");

  chk_status_mirror: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    data_req_i && !data_we_i && sel == BMAM_SEL_SFR && eff_ofs == OFS_STATUS
    |=> rdata_reg == $past(status_reg))
    else $error("status mirror read wrong");

  chk_status_write: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    status_wr |=> status_reg == $past(wdata_i))
    else $error("status write lost");

  chk_core_status: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    status_core_we_i && !status_wr |=>
    status_reg == $past(status_core_bits_i))
    else $error("core status update lost");

  chk_ptr_write: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    ptr_wr |=> file_select_pointer_reg == $past(wdata_i))
    else $error("pointer write lost");

  chk_indirect_nostore: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    data_req_i && data_we_i && sel == BMAM_SEL_SFR &&
    eff_ofs == OFS_INDIRECT && !status_core_we_i |=>
    $stable(status_reg) && $stable(file_select_pointer_reg))
    else $error("indirect location stored data");

  chk_rvalid_pulse: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    1'b1 |=> rvalid_reg == $past(data_req_i && !data_we_i))
    else $error("read valid not a pulse");

  chk_rdata_hold: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    !data_req_i |=> $stable(rdata_reg) && $stable(data_addr_reg))
    else $error("read data not held");

  chk_unimpl_zero: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    data_req_i && sel == BMAM_SEL_NONE |=> rdata_reg == 8'h00)
    else $error("unimplemented read not zero");

  chk_gpr_range: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    gpr_hit |-> gpr_index < 9'(GPR_WORDS))
    else $error("ram index out of range");

  chk_sel_onehot: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    $onehot(sel))
    else $error("decode select not one-hot");

  chk_shared_alias: assert property (@(posedge ref_clk_i)
    disable iff (reset_i)
    gpr_hit && eff_ofs >= OFS_SHARED_FIRST |-> gpr_index < 9'd96)
    else $error("shared area not aliased");
endmodule : bmam_address_map
`default_nettype wire

/* File: testbench/bmam_core_model.sv */
/*
  bmam_core_model: core fetch side, pulses and steps on request.
  assumes one core clock shared with the address map.
*/
`timescale 1ns/1ps
`default_nettype none
module bmam_core_model (
  input wire logic clk_i,
  output logic fetch_advance_o,
  output logic intr_take_o,
  output logic jump_o,
  output logic [12:0] jump_addr_o
);
  initial begin
    fetch_advance_o = 1'b0;
    intr_take_o = 1'b0;
    jump_o = 1'b0;
    jump_addr_o = 13'h0000;
  end
  task automatic step(input int n);
    @(posedge clk_i);
    fetch_advance_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    fetch_advance_o <= 1'b0;
  endtask : step
  task automatic intr_pulse;
    @(posedge clk_i);
    intr_take_o <= 1'b1;
    @(posedge clk_i);
    intr_take_o <= 1'b0;
  endtask : intr_pulse
  task automatic jump(input logic [12:0] a);
    @(posedge clk_i);
    jump_o <= 1'b1;
    jump_addr_o <= a;
    @(posedge clk_i);
    jump_o <= 1'b0;
    jump_addr_o <= ~a;
  endtask : jump
endmodule : bmam_core_model
`default_nettype wire

/* File: testbench/banked_memory_address_map_bench.sv */
/*
  bench for bmam_address_map, 4K variant.
  assumes bmam_core_model drives the fetch controls.
*/
`timescale 1ns/1ps
`default_nettype none
module banked_memory_address_map_bench;
  import bmam_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic data_req_i = 1'b0;
  logic data_we_i = 1'b0;
  logic [6:0] file_addr_i = 7'h00;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] st_bits = 8'h00;
  logic st_we = 1'b0;
  logic adv, intr, jmp, rvalid_o;
  logic [12:0] jaddr, fetch_addr_o, pc_o;
  logic [7:0] rdata_o, status_o, ptr_o;
  logic [8:0] data_addr_o;
  int n_errors = 0;
  int compares = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  bmam_core_model core_u (.clk_i(ref_clk_i), .fetch_advance_o(adv),
    .intr_take_o(intr), .jump_o(jmp), .jump_addr_o(jaddr));
  bmam_address_map #(.PMEM_DEPTH(PMEM_DEPTH_4K)) dut_u (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .fetch_advance_i(adv),
    .intr_take_i(intr), .jump_i(jmp), .jump_addr_i(jaddr),
    .fetch_addr_o(fetch_addr_o), .pc_o(pc_o), .data_req_i(data_req_i),
    .data_we_i(data_we_i), .file_addr_i(file_addr_i), .wdata_i(wdata_i),
    .status_core_bits_i(st_bits), .status_core_we_i(st_we),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .data_addr_o(data_addr_o),
    .status_o(status_o), .file_select_pointer_o(ptr_o));
  task automatic check(input logic [12:0] got, input logic [12:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic acc(input logic we, input logic [6:0] a,
                     input logic [7:0] d);
    @(posedge ref_clk_i);
    data_req_i <= 1'b1;
    data_we_i <= we;
    file_addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    data_req_i <= 1'b0;
    #1;
  endtask : acc
  task automatic core_st(input logic [7:0] v);
    @(posedge ref_clk_i);
    st_we <= 1'b1;
    st_bits <= v;
    @(posedge ref_clk_i);
    st_we <= 1'b0;
    #1;
  endtask : core_st
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    check({5'h00, rdata_o}, {5'h00, exp});
    check({12'h000, rvalid_o}, 13'h0001);
  endtask : rd
  task automatic complete_run;
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  initial begin
    #5000;
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    #1;
    check(pc_o, RESET_VECTOR);
    check(fetch_addr_o, RESET_VECTOR);
    core_u.step(3);
    #1;
    check(pc_o, 13'h0003);
    core_u.intr_pulse();
    #1;
    check(pc_o, INTR_VECTOR);
    core_u.jump(13'h1ffe);
    #1;
    check(fetch_addr_o, 13'h0ffe);
    core_u.step(2);
    #1;
    check(pc_o, 13'h0000);
    acc(1'b1, OFS_GPR_FIRST, 8'ha5);
    acc(1'b1, OFS_STATUS, 8'h20);
    acc(1'b1, OFS_GPR_FIRST, 8'h3c);
    check({4'h0, data_addr_o}, 13'h00a0);
    acc(1'b1, 7'h7f, 8'h77);
    acc(1'b1, OFS_STATUS, 8'h60);
    rd(OFS_STATUS, 8'h60);
    check({4'h0, data_addr_o}, 13'h0183);
    rd(7'h05, 8'h00);
    acc(1'b1, OFS_POINTER, 8'h21);
    acc(1'b1, OFS_STATUS, 8'h00);
    acc(1'b1, OFS_INDIRECT, 8'h5a);
    check({4'h0, data_addr_o}, 13'h0021);
    rd(7'h21, 8'h5a);
    rd(7'h7f, 8'h77);
    rd(OFS_GPR_FIRST, 8'ha5);
    fork
      core_u.step(1);
      rd(OFS_POINTER, 8'h21);
    join
    check(pc_o, 13'h0001);
    check({5'h00, ptr_o}, 13'h0021);
    core_st(8'h40);
    check({5'h00, status_o}, 13'h0040);
    acc(1'b1, OFS_GPR_FIRST, 8'h99);
    check({4'h0, data_addr_o}, 13'h0120);
    check({12'h000, rvalid_o}, 13'h0000);
    rd(OFS_GPR_FIRST, 8'h99);
    fork
      core_st(8'hc0);
      acc(1'b1, OFS_STATUS, 8'h00);
    join
    check({5'h00, status_o}, 13'h0000);
    acc(1'b1, OFS_POINTER, 8'h80);
    acc(1'b1, OFS_INDIRECT, 8'h5a);
    rd(OFS_INDIRECT, 8'h00);
    check({4'h0, data_addr_o}, 13'h0080);
    check({5'h00, status_o}, 13'h0000);
    check({5'h00, ptr_o}, 13'h0080);
    complete_run();
  end
endmodule : banked_memory_address_map_bench
`default_nettype wire
